// >>> verilog/dmsep_defines.vh
// Constants shared by the dual-mode serial EEPROM port design.
`ifndef DMSEP_DEFINES_VH
`define DMSEP_DEFINES_VH
// ============================================================
// Array and stream framing
`define DMSEP_ADDR_W      7
`define DMSEP_START_ADDR  7'h00
`define DMSEP_BITS_BYTE   4'h8
`define DMSEP_SLOT_LAST   4'h8
`define DMSEP_SYNC_CYC    4'h9
// Content of every array byte before its first write.
`define DMSEP_ERASED      8'hff
// ============================================================
// Bus slave
// Bus address of this slave; the value is arbitrary.
`define DMSEP_DEV_ADDR    7'h2b
`define DMSEP_PAGE_W      3
`define DMSEP_PAGE_DEPTH  8
// ============================================================
// Programming cycle length
`define DMSEP_TWR_MS      10
`define DMSEP_CLK_MHZ     50
`define DMSEP_TWR_CYC     (`DMSEP_TWR_MS * 1000 * `DMSEP_CLK_MHZ)
`endif

// >>> verilog/dmsep_sync.v
// Two-flop synchroniser for one asynchronous input level.
`timescale 1ns/10ps
module dmsep_sync (
  // Clock and reset
  input  wire clock,
  input  wire reset_n,
  // Level in and out
  input  wire din,
  output reg  dout_q
);
  reg meta_q;
  // ============================================================
  // Synchroniser
  // Reset value high, since the lines idle high and a low would
  // look like an edge right after reset.
  always @(posedge clock) begin
    if (!reset_n) begin
      meta_q <= 1'b1;
      dout_q <= 1'b1;
    end else begin
      meta_q <= din;
      dout_q <= meta_q;
    end
  end
endmodule // dmsep_sync

// >>> verilog/dmsep_fifo.v
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/10ps
module dmsep_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             clock,
  input  wire             reset_n,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wp_q;
  reg [AW-1:0]    rp_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;
  // ============================================================
  // Flags
  assign in_ready  = (cnt_q != DEPTH);
  assign out_valid = (cnt_q != 0);
  assign out_data  = mem[rp_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  // ============================================================
  // Pointers and storage
  always @(posedge clock) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
    if (!reset_n) begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // dmsep_fifo

// >>> verilog/dmsep_top.v
// Dual-mode serial EEPROM port: transmit-only stream and bus slave.
`timescale 1ns/10ps
`include "dmsep_defines.vh"
module dmsep_top #(
  parameter TWR_CYC = `DMSEP_TWR_CYC
) (
  // Clock and reset
  input  wire clock,
  input  wire reset_n,
  // Transmit-only clock pin
  input  wire vclk,
  // Bus pins; sda_oe_n low while this block drives SDA: stream bits, or low in bus mode
  input  wire scl,
  input  wire sda_in,
  output reg  sda_out_q,
  output reg  sda_oe_n_q,
  // Status
  output reg  bidir_mode_q,
  output reg  prog_busy_q
);
  // ============================================================
  // Local names
  localparam AW = `DMSEP_ADDR_W;
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_AACK = 3'h2;
  localparam ST_WORD = 3'h3;
  localparam ST_DATA = 3'h4;
  localparam ST_RD   = 3'h5;
  localparam ST_RACK = 3'h6;
  localparam ST_WACK = 3'h7;

  reg  [7:0]    array_q [0:(1<<AW)-1];
  wire          vclk_s;
  wire          scl_s;
  wire          sda_s;
  reg           vclk_p_q;
  reg           scl_p_q;
  reg           sda_p_q;
  reg  [3:0]    sync_cnt_q;
  reg  [3:0]    slot_q;
  reg  [AW-1:0] sptr_q;
  reg  [AW-1:0] ptr_q;
  reg  [2:0]    st_q;
  reg  [3:0]    bit_q;
  reg  [7:0]    sh_q;
  reg           rw_q;
  reg           wr_en_q;
  reg           have_word_q;
  reg  [AW-1:0] pbase_q;
  reg  [2:0]    pcnt_q;
  reg  [3:0]    plen_q;
  reg  [31:0]   twr_q;
  reg           drain_q;
  reg  [AW-1:0] dptr_q;
  wire          fifo_in_v;
  wire          fifo_in_r;
  wire          fifo_out_v;
  wire [7:0]    fifo_out_d;
  wire          vclk_rise;
  wire          scl_rise;
  wire          scl_fall;
  wire          start_c;
  wire          stop_c;
  wire [AW-1:0] last_addr;
  integer       i;

  // ============================================================
  // Pin synchronisers
  dmsep_sync u_vclk (.clock(clock), .reset_n(reset_n),
                     .din(vclk), .dout_q(vclk_s));
  dmsep_sync u_scl  (.clock(clock), .reset_n(reset_n),
                     .din(scl), .dout_q(scl_s));
  dmsep_sync u_sda  (.clock(clock), .reset_n(reset_n),
                     .din(sda_in), .dout_q(sda_s));

  // Edge and condition detection on synchronised levels.
  assign vclk_rise = vclk_s & ~vclk_p_q;
  assign scl_rise  = scl_s & ~scl_p_q;
  assign scl_fall  = ~scl_s & scl_p_q;
  assign start_c   = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_c    = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign last_addr = {AW{1'b1}};

  // Page bytes land in the FIFO and are committed after Stop; the
  // FIFO holds the page buffer so the programming path can stall.
  // Limitation: a page longer than the FIFO drops its newest bytes.
  assign fifo_in_v = (st_q == ST_DATA) && scl_rise && (bit_q == 4'h7)
                     && wr_en_q && fifo_in_r;

  dmsep_fifo #(.WIDTH(8), .DEPTH(16), .AW(4)) u_page (
    .clock    (clock),
    .reset_n  (reset_n),
    .in_valid (fifo_in_v),
    .in_ready (fifo_in_r),
    .in_data  ({sh_q[6:0], sda_s}),
    .out_valid(fifo_out_v),
    .out_ready(drain_q),
    .out_data (fifo_out_d)
  );

  // ============================================================
  // The array starts erased; a reset is not a power cycle, so the
  // contents survive it and the stream never shows unknown bits.
  initial begin
    for (i = 0; i < (1 << AW); i = i + 1) begin
      array_q[i] = `DMSEP_ERASED;
    end
  end
  // Writes come only from the page FIFO drain while programming.
  always @(posedge clock) begin
    if (drain_q && fifo_out_v) begin
      array_q[dptr_q] <= fifo_out_d;
    end
  end

  // ============================================================
  // Mode, stream and bus slave state.
  always @(posedge clock) begin
    if (!reset_n) begin
      vclk_p_q     <= 1'b1;
      scl_p_q      <= 1'b1;
      sda_p_q      <= 1'b1;
      bidir_mode_q <= 1'b0;
      sync_cnt_q   <= 4'h0;
      slot_q       <= 4'h0;
      sptr_q       <= `DMSEP_START_ADDR;
      ptr_q        <= `DMSEP_START_ADDR;
      sda_out_q    <= 1'b1;
      sda_oe_n_q   <= 1'b1;
      st_q         <= ST_IDLE;
      bit_q        <= 4'h0;
      sh_q         <= 8'h00;
      rw_q         <= 1'b0;
      wr_en_q      <= 1'b0;
      have_word_q  <= 1'b0;
      pbase_q      <= {AW{1'b0}};
      pcnt_q       <= 3'h0;
      plen_q       <= 4'h0;
      twr_q        <= 32'h0;
      prog_busy_q  <= 1'b0;
      drain_q      <= 1'b0;
      dptr_q       <= {AW{1'b0}};
    end else begin
      vclk_p_q <= vclk_s;
      scl_p_q  <= scl_s;
      sda_p_q  <= sda_s;
      if (!bidir_mode_q) begin
        // Streaming mode; SCL held high keeps us here.
        if (scl_fall) begin
          bidir_mode_q <= 1'b1;
          sda_oe_n_q   <= 1'b1;
          sda_out_q    <= 1'b1;
        end else if (vclk_rise) begin
          if (sync_cnt_q != `DMSEP_SYNC_CYC) begin
            sync_cnt_q <= sync_cnt_q + 4'h1;
            sda_oe_n_q <= 1'b1;
          end else begin
            // Tenth rising edge onward: one slot per edge.
            sda_oe_n_q <= 1'b0;
            if (slot_q == `DMSEP_SLOT_LAST) begin
              sda_out_q <= 1'b1;
              slot_q    <= 4'h0;
              sptr_q    <= (sptr_q == last_addr) ?
                           `DMSEP_START_ADDR : sptr_q + 1'b1;
            end else begin
              sda_out_q <= array_q[sptr_q][3'h7 - slot_q[2:0]];
              slot_q    <= slot_q + 4'h1;
            end
          end
        end
      end else begin
        // Bus mode persists; no path back to streaming.
        if (prog_busy_q) begin
          if (twr_q == TWR_CYC - 1) begin
            prog_busy_q <= 1'b0;
            drain_q     <= 1'b0;
          end else begin
            twr_q <= twr_q + 32'h1;
          end
          if (drain_q && fifo_out_v) begin
            dptr_q <= {dptr_q[AW-1:`DMSEP_PAGE_W],
                       dptr_q[`DMSEP_PAGE_W-1:0] + 3'h1};
          end
        end
        if (start_c) begin
          st_q       <= ST_ADDR;
          bit_q      <= 4'h0;
          sda_oe_n_q <= 1'b1;
        end else if (stop_c) begin
          st_q       <= ST_IDLE;
          sda_oe_n_q <= 1'b1;
          if (have_word_q && plen_q != 4'h0 && !prog_busy_q) begin
            prog_busy_q <= 1'b1;
            drain_q     <= 1'b1;
            twr_q       <= 32'h0;
            // Drain from the start word address in arrival order; bytes that
            // wrapped the page land later and replace older ones.
            dptr_q <= pbase_q;
            ptr_q  <= {pbase_q[AW-1:`DMSEP_PAGE_W], pcnt_q};
          end
          have_word_q <= 1'b0;
        end else begin
          case (st_q)
            ST_IDLE: begin
              sda_oe_n_q <= 1'b1;
            end
            ST_ADDR, ST_WORD, ST_DATA: begin
              if (scl_rise) begin
                sh_q  <= {sh_q[6:0], sda_s};
                bit_q <= bit_q + 4'h1;
              end else if (scl_fall && bit_q == `DMSEP_BITS_BYTE) begin
                bit_q <= 4'h0;
                if (st_q == ST_ADDR) begin
                  rw_q <= sh_q[0];
                  if (sh_q[7:1] == `DMSEP_DEV_ADDR && !prog_busy_q) begin
                    sda_oe_n_q <= 1'b0;
                    sda_out_q  <= 1'b0;
                    st_q       <= ST_AACK;
                  end else begin
                    st_q <= ST_IDLE;
                  end
                end else if (st_q == ST_WORD) begin
                  ptr_q       <= sh_q[AW-1:0];
                  pbase_q     <= sh_q[AW-1:0];
                  pcnt_q      <= sh_q[2:0];
                  plen_q      <= 4'h0;
                  have_word_q <= 1'b1;
                  sda_oe_n_q  <= 1'b0;
                  sda_out_q   <= 1'b0;
                  st_q        <= ST_WACK;
                end else begin
                  if (plen_q != 4'h9) begin
                    plen_q <= plen_q + 4'h1;
                  end
                  pcnt_q     <= pcnt_q + 3'h1;
                  sda_oe_n_q <= 1'b0;
                  sda_out_q  <= 1'b0;
                  st_q       <= ST_WACK;
                end
              end
            end
            ST_AACK, ST_WACK: begin
              // Release after the ninth pulse; then load read data.
              if (scl_fall) begin
                if (st_q == ST_AACK && rw_q) begin
                  sda_oe_n_q <= array_q[ptr_q][7];
                  sda_out_q  <= 1'b0;
                  sh_q       <= {array_q[ptr_q][6:0], 1'b1};
                  ptr_q      <= ptr_q + 1'b1;
                  bit_q      <= 4'h1;
                  st_q       <= ST_RD;
                end else begin
                  sda_oe_n_q <= 1'b1;
                  wr_en_q    <= vclk_s;
                  st_q       <= (st_q == ST_AACK) ? ST_WORD : ST_DATA;
                end
              end
            end
            ST_RD: begin
              if (scl_fall) begin
                if (bit_q == `DMSEP_BITS_BYTE) begin
                  sda_oe_n_q <= 1'b1;
                  st_q       <= ST_RACK;
                end else begin
                  sda_oe_n_q <= sh_q[7];
                  sh_q       <= {sh_q[6:0], 1'b1};
                  bit_q      <= bit_q + 4'h1;
                end
              end
            end
            ST_RACK: begin
              if (scl_rise) begin
                // Master ack continues; no ack leaves SDA high.
                st_q <= sda_s ? ST_IDLE : ST_AACK;
              end
            end
            default: begin
              st_q <= ST_IDLE;
            end
          endcase
        end
      end
    end
  end
endmodule // dmsep_top

// >>> verification/dmsep_checker_properties.sv
// Pin-level checker for the dual-mode serial EEPROM port.
`timescale 1ns/10ps
module dmsep_checker #(
  parameter TWR_CYC = 200
) (
  // Clock and reset
  input wire clock,
  input wire reset_n,
  // Pins
  input wire vclk,
  input wire scl,
  input wire sda_in,
  input wire sda_out_q,
  input wire sda_oe_n_q,
  // Status
  input wire bidir_mode_q,
  input wire prog_busy_q
);
  reg [3:0]  vrise_q;
  reg [31:0] busy_q;
  // =====================================================
  // Counters: display clock rises (held at ten), busy span.
  always @(posedge clock) begin
    if (!reset_n) begin
      vrise_q <= 4'h0;
      busy_q  <= 32'h0;
    end else begin
      if ($rose(vclk) && vrise_q != 4'ha)
        vrise_q <= vrise_q + 4'h1;
      busy_q <= prog_busy_q ? busy_q + 32'h1 : 32'h0;
    end
  end
  // =====================================================
  // Properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_boot; $rose(reset_n) |-> !bidir_mode_q && sda_oe_n_q; endproperty
  property p_sync; !bidir_mode_q && vrise_q < 4'ha |-> sda_oe_n_q; endproperty
  property p_first;
    vrise_q == 4'h9 && $rose(vclk) && !bidir_mode_q |-> ##[2:6] !sda_oe_n_q;
  endproperty
  // Stream data only moves near a display clock rise.
  property p_vgap;
    !bidir_mode_q && !vclk && !$past(vclk) && !$past(vclk, 2)
      |-> $stable(sda_out_q);
  endproperty
  property p_enter; $fell(scl) && !bidir_mode_q |-> ##[1:6] bidir_mode_q;
  endproperty
  property p_cause; $rose(bidir_mode_q) |-> !scl; endproperty
  property p_stay; bidir_mode_q |=> bidir_mode_q; endproperty
  property p_drain;
    bidir_mode_q && $past(bidir_mode_q) && !sda_oe_n_q |-> !sda_out_q;
  endproperty
  property p_steady; bidir_mode_q && $changed(sda_oe_n_q) |-> !scl;
  endproperty
  property p_busy; prog_busy_q |-> sda_oe_n_q; endproperty
  property p_blen; busy_q <= TWR_CYC + 2; endproperty
  a_boot: assert property (p_boot) else $error("bad power-up state");
  a_sync: assert property (p_sync) else $error("sda driven in sync");
  a_first: assert property (p_first) else $error("no first bit");
  a_vgap: assert property (p_vgap) else $error("stream bit moved");
  a_enter: assert property (p_enter) else $error("mode not entered");
  a_cause: assert property (p_cause) else $error("mode without scl");
  a_stay: assert property (p_stay) else $error("bus mode left");
  a_drain: assert property (p_drain) else $error("sda driven high");
  a_steady: assert property (p_steady) else $error("sda moved");
  a_busy: assert property (p_busy) else $error("ack while busy");
  a_blen: assert property (p_blen) else $error("busy too long");
  c_mode: cover property ($rose(bidir_mode_q));
  c_prog: cover property ($rose(prog_busy_q));
  c_ack: cover property (bidir_mode_q && !sda_oe_n_q);
endmodule // dmsep_checker
bind dmsep_top dmsep_checker #(.TWR_CYC(TWR_CYC)) u_chk (
  .clock(clock), .reset_n(reset_n), .vclk(vclk), .scl(scl),
  .sda_in(sda_in), .sda_out_q(sda_out_q), .sda_oe_n_q(sda_oe_n_q),
  .bidir_mode_q(bidir_mode_q), .prog_busy_q(prog_busy_q));

// >>> verification/dmsep_host.sv
// Host model: display clock source and bus master on one SDA.
`timescale 1ns/10ps
module dmsep_host (
  // Clock
  input  wire clock,
  // Device SDA drive
  input  wire sda_out_q,
  input  wire sda_oe_n_q,
  // Pins towards the device
  output reg  vclk,
  output reg  scl,
  output wire sda_in
);
  reg m_sda;
  reg got;
  // Device drive wins; released master reads as the pull-up.
  assign sda_in = sda_oe_n_q ? m_sda : sda_out_q;
  initial begin
    vclk  = 1'b0;
    scl   = 1'b1;
    m_sda = 1'b1;
    got   = 1'b1;
  end
  // Set the three pins, then hold them n cycles.
  task pins(input v, input s, input d, input integer n);
    begin
      vclk  <= v;
      scl   <= s;
      m_sda <= d;
      repeat (n) @(posedge clock);
    end
  endtask
  // One 160 ns display clock; sample just before the next rise.
  task vbit;
    begin
      pins(1'b1, scl, m_sda, 4);
      pins(1'b0, scl, m_sda, 4);
      #1 got = sda_in;
    end
  endtask
  // One bus bit; SDA moves only while SCL is low.
  task bbit(input b);
    begin
      pins(vclk, 1'b0, b, 10);
      pins(vclk, 1'b1, b, 10);
      got = sda_in;
      pins(vclk, 1'b0, b, 10);
    end
  endtask
  // Byte out and in, most significant first, then the ack slot.
  task xfer(input [7:0] tx, input am, output [7:0] rx, output ak);
    integer n;
    begin
      for (n = 7; n >= 0; n = n - 1) begin
        bbit(tx[n]);
        rx[n] = got;
      end
      bbit(am);
      ak = got;
    end
  endtask
  // Start and Stop: SDA moves while SCL is high.
  task start;
    begin
      pins(vclk, scl, 1'b1, 10);
      pins(vclk, 1'b1, 1'b1, 10);
      pins(vclk, 1'b1, 1'b0, 10);
      pins(vclk, 1'b0, 1'b0, 10);
    end
  endtask
  task stop;
    begin
      pins(vclk, 1'b0, 1'b0, 10);
      pins(vclk, 1'b1, 1'b0, 10);
      pins(vclk, 1'b1, 1'b1, 10);
    end
  endtask
endmodule // dmsep_host

// >>> verification/tb_top.sv
// Self-checking bench for the dual-mode serial EEPROM port.
`timescale 1ns/10ps
`include "dmsep_defines.vh"
module tb_top;
  reg        clock;
  reg        reset_n;
  wire       vclk, scl, sda_in, sda_out_q, sda_oe_n_q;
  wire       bidir_mode_q, prog_busy_q;
  integer    failures, tests_run, seed, k;
  reg  [7:0] mem [0:7];
  reg  [7:0] rx;
  reg        ak;
  reg [31:0] rnd;
  // =====================================================
  // Design and host; the write time is short to keep the run brief,
  // yet longer than one Start plus control byte so a poll is refused.
  dmsep_top #(.TWR_CYC(600)) u_dut (.clock(clock), .reset_n(reset_n),
    .vclk(vclk), .scl(scl), .sda_in(sda_in), .sda_out_q(sda_out_q),
    .sda_oe_n_q(sda_oe_n_q), .bidir_mode_q(bidir_mode_q),
    .prog_busy_q(prog_busy_q));
  dmsep_host u_host (.clock(clock), .sda_out_q(sda_out_q),
    .sda_oe_n_q(sda_oe_n_q), .vclk(vclk), .scl(scl), .sda_in(sda_in));
  // Clock, and a watchdog well past the roughly 18400 cycles needed.
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    #1500000;
    failures = failures + 1;
    end_of_test;
  end
  task check(input [63:0] nm, input [7:0] got, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("unexpected %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task end_of_test;
    begin
      if (failures == 0 && tests_run > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // Expected stream bit n: eight data bits then a null one.
  function [7:0] sbit(input integer n);
    sbit = (n % 9 == 8) ? 8'h01 : {7'h00, mem[(n / 9) % 8][7 - n % 9]};
  endfunction
  task do_reset;
    begin
      reset_n <= 1'b0;
      repeat (16) @(posedge clock);
      reset_n <= 1'b1;
      repeat (4) @(posedge clock);
    end
  endtask
  // Start and control byte; a low ack slot means acknowledged.
  task ctl(input [6:0] a, input rw, input [7:0] exp);
    begin
      u_host.start;
      u_host.xfer({a, rw}, 1'b1, rx, ak);
      check("ctl_ack", ak, exp);
    end
  endtask
  // Bounded wait for the programming cycle to end.
  task idle;
    integer j;
    begin
      for (j = 0; j < 1000 && prog_busy_q !== 1'b0; j = j + 1)
        @(posedge clock);
      check("busy", prog_busy_q, 0);
    end
  endtask
  // =====================================================
  // Main sequence
  initial begin
    seed = 32'h2a9cbca5;
    failures = 0;
    tests_run = 0;
    reset_n = 1'b0;
    do_reset;
    check("mode", bidir_mode_q, 0);
    for (k = 0; k < 10; k = k + 1) begin
      u_host.vbit;
      check("oe_n", sda_oe_n_q, k < 9);
    end
    u_host.pins(1'b1, 1'b0, 1'b1, 10);
    u_host.stop;
    check("mode", bidir_mode_q, 1);
    ctl(`DMSEP_DEV_ADDR ^ 7'h01, 1'b0, 1);
    u_host.stop;
    ctl(`DMSEP_DEV_ADDR, 1'b0, 0);
    u_host.xfer(8'h00, 1'b1, rx, ak);
    for (k = 0; k < 10; k = k + 1) begin
      rnd = $random(seed);
      mem[k % 8] = rnd[7:0];
      u_host.xfer(mem[k % 8], 1'b1, rx, ak);
      check("data_ack", ak, 0);
    end
    u_host.stop;
    check("busy", prog_busy_q, 1);
    ctl(`DMSEP_DEV_ADDR, 1'b0, 1);
    u_host.stop;
    idle;
    // A write with the display clock low must leave the array alone.
    u_host.pins(1'b0, 1'b1, 1'b1, 10);
    ctl(`DMSEP_DEV_ADDR, 1'b0, 0);
    u_host.xfer(8'h03, 1'b1, rx, ak);
    u_host.xfer(~mem[3], 1'b1, rx, ak);
    u_host.stop;
    idle;
    ctl(`DMSEP_DEV_ADDR, 1'b0, 0);
    u_host.xfer(8'h00, 1'b1, rx, ak);
    ctl(`DMSEP_DEV_ADDR, 1'b1, 0);
    for (k = 0; k < 8; k = k + 1) begin
      u_host.xfer(8'hff, k == 7, rx, ak);
      check("rd_data", rx, mem[k]);
    end
    check("release", sda_oe_n_q, 1);
    u_host.stop;
    u_host.vbit;
    check("mode", bidir_mode_q, 1);
    do_reset;
    check("mode", bidir_mode_q, 0);
    for (k = 0; k < 1170; k = k + 1) begin
      u_host.vbit;
      if (k >= 9 && (k - 9) % 1152 < 72)
        check("stream", u_host.got, sbit(k - 9));
    end
    end_of_test;
  end
endmodule // tb_top
